// ==== design/dsadc_top.sv ====
// phase sequencer, timebase and register slave of the dual-slope converter control
// assumes converter comparator and host pins synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module dsadc_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // converter side
  input  wire logic        zero_cross_in,
  output logic             step_sel_hi,
  output logic             step_sel_lo,
  // host serial port
  input  wire logic        read_n,
  input  wire logic        load_n,
  input  wire logic        shift_clock,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // conversion control and status pins
  input  wire logic        conv_enable_n,
  output logic             result_valid_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import dsadc_pkg::*;

  dsadc_phase_t           phase_r;
  dsadc_phase_t           phase_nxt;
  logic [1:0]             div_r;
  logic                   tick;
  logic [15:0]            tb_r;
  logic [15:0]            down_r;
  logic                   ovf_r;
  logic                   sign_r;
  logic [DSADC_RES_W-1:0] result_r;
  logic [7:0]             preset_r;
  logic [7:0]             ser_preset;
  logic                   ser_stb;
  logic                   hold_r;
  logic                   halt;
  logic                   cmp_d;
  logic                   cmp_fall;
  logic                   tb_done;
  logic                   req;
  logic                   take;
  logic [31:0]            rd_nxt;

  // halt from pin or software hold bit
  assign halt     = conv_enable_n | hold_r;
  assign cmp_fall = cmp_d & ~zero_cross_in;
  assign tb_done  = (tb_r == {8'hff, DSADC_TB_LOW});

  // tick divider, one pulse every four clocks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick = (div_r == 2'(DSADC_TICK_DIV - 1));

  // comparator history for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_d <= 1'b0;
    end else begin
      cmp_d <= zero_cross_in;
    end
  end

  // serial port
  dsadc_serial i_dsadc_serial (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .read_n        (read_n),
    .load_n        (load_n),
    .shift_clock   (shift_clock),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .result        (result_r),
    .preset_byte   (ser_preset),
    .preset_stb    (ser_stb)
  );

  // preset register, written by serial load or by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preset_r <= DSADC_PRESET_RST;
    end else if (ser_stb) begin
      preset_r <= ser_preset;
    end else if (take && avs_write && avs_address == DSADC_REG_PRESET && avs_byteenable[0]) begin
      preset_r <= avs_writedata[7:0];
    end
  end

  // next phase
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      DSADC_CLEAR: begin
        if (zero_cross_in) begin
          phase_nxt = DSADC_NULL;
        end
      end
      DSADC_NULL: begin
        if (tick && tb_done) begin
          phase_nxt = DSADC_UP;
        end
      end
      DSADC_UP: begin
        if (tick && tb_done) begin
          phase_nxt = DSADC_DOWN;
        end
      end
      DSADC_DOWN: begin
        if (cmp_fall) begin
          phase_nxt = DSADC_CLEAR;
        end
      end
    endcase
    if (halt) begin
      phase_nxt = DSADC_NULL;
    end
  end

  // phase register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= DSADC_CLEAR;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // phase select pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {step_sel_hi, step_sel_lo} <= DSADC_SEL_CLEAR;
    end else begin
      unique case (phase_nxt)
        DSADC_CLEAR: {step_sel_hi, step_sel_lo} <= DSADC_SEL_CLEAR;
        DSADC_NULL:  {step_sel_hi, step_sel_lo} <= DSADC_SEL_NULL;
        DSADC_UP:    {step_sel_hi, step_sel_lo} <= DSADC_SEL_UP;
        DSADC_DOWN:  {step_sel_hi, step_sel_lo} <= DSADC_SEL_DOWN;
      endcase
    end
  end

  // result valid low exactly while in offset null
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_valid_n <= 1'b1;
    end else begin
      result_valid_n <= (phase_nxt != DSADC_NULL);
    end
  end

  // timebase: starts at preset in upper byte, ends at all ones
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tb_r <= '0;
    end else if (phase_nxt != phase_r || halt) begin
      tb_r <= {preset_r, 8'h00};
    end else if (tick && (phase_r == DSADC_NULL || phase_r == DSADC_UP)) begin
      tb_r <= tb_r + 16'h0001;
    end
  end

  // ramp-down counter with overflow as seventeenth bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      down_r <= '0;
      ovf_r  <= 1'b0;
      sign_r <= 1'b0;
    end else if (phase_r == DSADC_UP && phase_nxt == DSADC_DOWN) begin
      down_r <= '0;
      ovf_r  <= 1'b0;
      sign_r <= zero_cross_in;
    end else if (phase_r == DSADC_DOWN && tick) begin
      down_r <= down_r + 16'h0001;
      if (down_r == 16'hffff) begin
        ovf_r <= 1'b1;
      end
    end
  end

  // stored result, updated as a new cycle enters offset null
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
    end else if (phase_r == DSADC_CLEAR && phase_nxt == DSADC_NULL && !halt) begin
      result_r <= {ovf_r, sign_r, down_r};
    end
  end

  // bus handshake: one wait cycle, then accept
  assign req  = avs_read | avs_write;
  assign take = req & ~avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else if (take && avs_write && avs_address == DSADC_REG_CTRL && avs_byteenable[0]) begin
      hold_r <= avs_writedata[DSADC_CTRL_HOLD];
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_nxt = '0;
    unique case (avs_address)
      DSADC_REG_CTRL:   rd_nxt[DSADC_CTRL_HOLD] = hold_r;
      DSADC_REG_PRESET: rd_nxt[7:0] = preset_r;
      DSADC_REG_STATUS: begin
        rd_nxt[1:0]                = phase_r;
        rd_nxt[DSADC_STAT_VALID_N] = result_valid_n;
        rd_nxt[DSADC_STAT_OVF]     = ovf_r;
        rd_nxt[DSADC_STAT_CE]      = conv_enable_n;
      end
      DSADC_REG_RESULT: rd_nxt[DSADC_RES_W-1:0] = result_r;
      default:          rd_nxt = '0;
    endcase
  end

  // read data latched as waitrequest drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== design/dsadc_pkg.sv ====
// constants, phase encoding and register map of the dual-slope converter sequencer
// assumes a 250 MHz system clock and Avalon-MM register access
package dsadc_pkg;

  // sequencer phases
  typedef enum logic [1:0] {
    DSADC_CLEAR,
    DSADC_NULL,
    DSADC_UP,
    DSADC_DOWN
  } dsadc_phase_t;

  // phase select codes {hi, lo}
  localparam logic [1:0] DSADC_SEL_NULL  = 2'h1;
  localparam logic [1:0] DSADC_SEL_UP    = 2'h2;
  localparam logic [1:0] DSADC_SEL_DOWN  = 2'h3;
  localparam logic [1:0] DSADC_SEL_CLEAR = 2'h0;

  // timing
  localparam int unsigned DSADC_TICK_DIV   = 4;
  localparam logic [7:0]  DSADC_TB_LOW     = 8'hff;
  localparam logic [7:0]  DSADC_PRESET_RST = 8'h00;
  localparam logic [7:0]  DSADC_PRESET_HI  = 8'h00;
  localparam logic [7:0]  DSADC_PRESET_LO  = 8'h80;
  localparam int unsigned DSADC_RES_W      = 18;
  localparam int unsigned DSADC_MAG_W      = 16;

  // register map, byte addresses
  localparam logic [3:0] DSADC_REG_CTRL   = 4'h0;
  localparam logic [3:0] DSADC_REG_PRESET = 4'h4;
  localparam logic [3:0] DSADC_REG_STATUS = 4'h8;
  localparam logic [3:0] DSADC_REG_RESULT = 4'hc;

  // field positions
  localparam int unsigned DSADC_CTRL_HOLD    = 0;
  localparam int unsigned DSADC_STAT_VALID_N = 2;
  localparam int unsigned DSADC_STAT_OVF     = 3;
  localparam int unsigned DSADC_STAT_CE      = 4;

endpackage

// ==== design/dsadc_serial.sv ====
// three-wire serial port: result read-out and preset load
// assumes pins already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module dsadc_serial (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // pins
  input  wire logic                              read_n,
  input  wire logic                              load_n,
  input  wire logic                              shift_clock,
  input  wire logic                              serial_in,
  output logic                                   serial_out,
  output logic                                   serial_out_oe,
  // core side
  input  wire logic [dsadc_pkg::DSADC_RES_W-1:0] result,
  output logic [7:0]                             preset_byte,
  output logic                                   preset_stb
);
  import dsadc_pkg::*;

  logic                   read_n_d;
  logic                   load_n_d;
  logic                   sclk_d;
  logic [DSADC_RES_W-1:0] out_sr;
  logic [7:0]             in_sr;
  logic [3:0]             in_cnt;
  logic                   sclk_rise;
  logic                   sclk_fall;

  assign sclk_rise = shift_clock & ~sclk_d;
  assign sclk_fall = ~shift_clock & sclk_d;

  // edge history of pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      read_n_d <= 1'b1;
      load_n_d <= 1'b1;
      sclk_d   <= 1'b0;
    end else begin
      read_n_d <= read_n;
      load_n_d <= load_n;
      sclk_d   <= shift_clock;
    end
  end

  // read-out shifter, msb goes out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_sr <= '0;
    end else if (!read_n && read_n_d) begin
      out_sr <= result;
    end else if (!read_n && sclk_fall) begin
      out_sr <= {out_sr[DSADC_RES_W-2:0], out_sr[DSADC_RES_W-1]};
    end
  end

  // enable follows read level, pin takes msb at read start, next bit on clock falls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= ~read_n;
      if (!read_n && read_n_d) begin
        serial_out <= result[DSADC_RES_W-1];
      end else if (!read_n && sclk_fall) begin
        serial_out <= out_sr[DSADC_RES_W-2];
      end
    end
  end

  // preset byte shifts in on rising edges while load low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_sr       <= '0;
      in_cnt      <= '0;
      preset_byte <= DSADC_PRESET_RST;
      preset_stb  <= 1'b0;
    end else begin
      preset_stb <= 1'b0;
      if (!load_n && load_n_d) begin
        in_cnt <= '0;
      end else if (!load_n && sclk_rise) begin
        in_sr  <= {in_sr[6:0], serial_in};
        if (in_cnt != 4'h8) begin
          in_cnt <= in_cnt + 4'h1;
        end
      end else if (load_n && !load_n_d) begin
        preset_stb <= 1'b1;
        if (in_cnt == 4'h0) begin
          preset_byte <= serial_in ? DSADC_PRESET_HI : DSADC_PRESET_LO;
        end else begin
          preset_byte <= in_sr;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/dsadc_top_sva.sv ====
// checker of phase order, valid flag and serial pin timing
// assumes binding onto dsadc_top, one clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module dsadc_top_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched pins
  input wire logic zero_cross_in,
  input wire logic step_sel_hi,
  input wire logic step_sel_lo,
  input wire logic read_n,
  input wire logic shift_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic conv_enable_n,
  input wire logic result_valid_n
);
  wire logic [1:0] sel = {step_sel_hi, step_sel_lo};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // phase pins against their causes
  a_force_null: assert property (conv_enable_n [*4] |-> sel == 2'h1)
    else $error("phase not null while halted");
  a_valid_null: assert property ($stable(sel) |-> result_valid_n == (sel != 2'h1))
    else $error("valid flag differs from null phase");
  a_null_to_up: assert property ($past(sel) == 2'h1 && sel != 2'h1 |-> sel == 2'h2)
    else $error("null not followed by ramp-up");
  a_down_exit: assert property ($past(sel) == 2'h3 && sel != 2'h3 |-> sel inside {2'h0, 2'h1})
    else $error("ramp-down left to wrong phase");
  a_down_ends: assert property (sel == 2'h3 && $fell(zero_cross_in) && !conv_enable_n
    |-> ##[1:12] sel == 2'h0)
    else $error("ramp-down not ended by comparator fall");
  a_down_holds: assert property ((sel == 2'h3 && zero_cross_in && !conv_enable_n) [*3]
    |=> sel == 2'h3)
    else $error("ramp-down ended without comparator fall");
  a_clear_holds: assert property ((sel == 2'h0 && !zero_cross_in && !conv_enable_n) [*3]
    |=> sel == 2'h0)
    else $error("clear left while comparator low");
  // serial pin
  a_oe_tracks: assert property (serial_out_oe == !$past(read_n))
    else $error("serial pin enable does not follow read");
  a_out_stable: assert property ((!read_n && shift_clock) [*3] |-> $stable(serial_out))
    else $error("serial data moved without clock fall");
endmodule
bind dsadc_top dsadc_top_sva i_dsadc_top_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .zero_cross_in(zero_cross_in),
  .step_sel_hi(step_sel_hi), .step_sel_lo(step_sel_lo), .read_n(read_n),
  .shift_clock(shift_clock), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .conv_enable_n(conv_enable_n), .result_valid_n(result_valid_n));
`default_nettype wire

// ==== verif/dsadc_host_model.sv ====
// host side of the three-wire port: preset load and result read-out
// assumes tasks are called right after a rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module dsadc_host_model (
  // clock
  input  wire logic clk_sys,
  // serial pins toward the device
  output logic      read_n,
  output logic      load_n,
  output logic      shift_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic last_r;
  logic dout;
  // a released pin shows the inverse of its last driven level
  always @(posedge clk_sys) if (serial_out_oe) last_r <= serial_out;
  assign dout = serial_out_oe ? serial_out : ~last_r;
  initial begin
    read_n = 1'b1;
    load_n = 1'b1;
    shift_clock = 1'b0;
    serial_in = 1'b0;
    last_r = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // preset byte msb first, half period hp keeps the clock under 3 MHz
  task automatic load_byte(input logic [7:0] b, input int hp);
    load_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_in <= b[i];
      wait_clk(hp);
      shift_clock <= 1'b1;
      wait_clk(hp);
      shift_clock <= 1'b0;
    end
    wait_clk(hp);
    load_n <= 1'b1;
    wait_clk(4);
  endtask
  // load pulse with no clock edges, serial_in picks the default
  task automatic pulse_load(input logic v);
    serial_in <= v;
    wait_clk(63);
    load_n <= 1'b0;
    wait_clk(63);
    load_n <= 1'b1;
    wait_clk(4);
  endtask
  // reads n bits, then ends the read early or at the word end
  task automatic read_bits(output logic [17:0] w, input int n, input int hp);
    w = '0;
    read_n <= 1'b0;
    wait_clk(hp);
    for (int i = 17; i > 17 - n; i--) begin
      w[i] = dout;
      shift_clock <= 1'b1;
      wait_clk(hp);
      shift_clock <= 1'b0;
      wait_clk(hp);
    end
    read_n <= 1'b1;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_dsadc_top.sv ====
// self-checking bench of the converter sequencer, serial port and registers
// assumes dsadc_top, its package, the host model and the checker
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_dsadc_top;
  import dsadc_pkg::*;
  logic        clk_sys, rst_n, zero_cross_in, conv_enable_n;
  logic        step_sel_hi, step_sel_lo, serial_out, serial_out_oe, result_valid_n;
  logic        read_n, load_n, shift_clock, serial_in;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [17:0] w, w2;
  int          fails, n_compared, n;
  wire logic [1:0] sel = {step_sel_hi, step_sel_lo};
  dsadc_top i_dsadc_top (.clk_sys(clk_sys), .rst_n(rst_n), .zero_cross_in(zero_cross_in),
    .step_sel_hi(step_sel_hi), .step_sel_lo(step_sel_lo), .read_n(read_n), .load_n(load_n),
    .shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .conv_enable_n(conv_enable_n),
    .result_valid_n(result_valid_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dsadc_host_model i_dsadc_host_model (.clk_sys(clk_sys), .read_n(read_n), .load_n(load_n),
    .shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for a phase code, n counts the cycles
  task automatic wait_sel(input logic [1:0] v, input int max);
    n = 0;
    while (sel !== v) begin
      @(posedge clk_sys);
      n++;
      if (n > max) begin
        `chk("phase wait", v, sel)
        end_sim();
      end
    end
  endtask
  // one avalon transfer held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++) @(posedge clk_sys);
    if (n == 50) begin
      `chk("bus answer", 1'b0, avs_waitrequest)
      end_sim();
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_idle();
    repeat (20) @(posedge clk_sys);
    `chk("phase at start", 2'h0, sel)
    `chk("serial enable idle", 1'b0, serial_out_oe)
    xfer(1'b0, 4'h2, '0, 4'hf);
    `chk("unmapped read", 32'h0, d)
  endtask
  task automatic t_preset();
    i_dsadc_host_model.pulse_load(1'b0);
    xfer(1'b0, DSADC_REG_PRESET, '0, 4'hf);
    `chk("bare load low", DSADC_PRESET_LO, d[7:0])
    i_dsadc_host_model.pulse_load(1'b1);
    xfer(1'b0, DSADC_REG_PRESET, '0, 4'hf);
    `chk("bare load high", DSADC_PRESET_HI, d[7:0])
    xfer(1'b1, DSADC_REG_PRESET, 32'h5a, 4'h0);
    xfer(1'b0, DSADC_REG_PRESET, '0, 4'hf);
    `chk("masked write", DSADC_PRESET_HI, d[7:0])
    xfer(1'b1, 4'h2, 32'h33, 4'hf);
    xfer(1'b0, 4'h2, '0, 4'hf);
    `chk("unmapped write", 32'h0, d)
    i_dsadc_host_model.load_byte(8'hff, 42);
    xfer(1'b0, DSADC_REG_PRESET, '0, 4'hf);
    `chk("serial preset", 8'hff, d[7:0])
  endtask
  // one conversion with 100 ticks of ramp-down, then a full read
  task automatic t_convert();
    zero_cross_in <= 1'b1;
    wait_sel(2'h1, 100);
    wait_sel(2'h2, 1100);
    `chk("null length", 1'b1, n >= 1016 && n <= 1032)
    wait_sel(2'h3, 1100);
    `chk("ramp-up length", 1'b1, n >= 1016 && n <= 1032)
    repeat (400) @(posedge clk_sys);
    zero_cross_in <= 1'b0;
    wait_sel(2'h0, 12);
    repeat (40) @(posedge clk_sys);
    zero_cross_in <= 1'b1;
    wait_sel(2'h1, 20);
    repeat (2) @(posedge clk_sys);
    `chk("valid at new cycle", 1'b0, result_valid_n)
    i_dsadc_host_model.read_bits(w, 18, 42);
    `chk("overflow bit", 1'b0, w[17])
    `chk("sign bit", 1'b1, w[16])
    `chk("magnitude", 1'b1, w[15:0] >= 16'h62 && w[15:0] <= 16'h67)
    xfer(1'b0, DSADC_REG_RESULT, '0, 4'hf);
    `chk("result upper", 16'h0001, d[31:16])
    `chk("result magnitude", 1'b1, d[15:0] >= 16'h62 && d[15:0] <= 16'h67)
  endtask
  // early end of a slow read, result still held
  task automatic t_abort();
    i_dsadc_host_model.read_bits(w2, 5, 60);
    repeat (2) @(posedge clk_sys);
    `chk("released after abort", 1'b0, serial_out_oe)
    `chk("held result", 5'h08, w2[17:13])
  endtask
  // halt during null, then resume
  task automatic t_enable();
    zero_cross_in <= 1'b0;
    wait_sel(2'h0, 2000);
    zero_cross_in <= 1'b1;
    wait_sel(2'h1, 20);
    conv_enable_n <= 1'b1;
    repeat (2000) @(posedge clk_sys);
    `chk("halted phase", 2'h1, sel)
    `chk("valid while halted", 1'b0, result_valid_n)
    conv_enable_n <= 1'b0;
    wait_sel(2'h2, 1100);
  endtask
  // software hold and bus preset, then a run with the new preset
  task automatic t_hold();
    xfer(1'b0, DSADC_REG_CTRL, '0, 4'hf);
    `chk("hold after stray write", 32'h0, d)
    xfer(1'b1, DSADC_REG_CTRL, 32'h1, 4'h1);
    xfer(1'b1, DSADC_REG_PRESET, 32'hfe, 4'h1);
    xfer(1'b0, DSADC_REG_STATUS, '0, 4'hf);
    `chk("status while held", 5'h01, d[4:0])
    `chk("phase while held", 2'h1, sel)
    xfer(1'b0, DSADC_REG_PRESET, '0, 4'hf);
    `chk("bus preset", 8'hfe, d[7:0])
    xfer(1'b1, DSADC_REG_CTRL, 32'h0, 4'h1);
    wait_sel(2'h2, 2100);
    `chk("null length bus preset", 1'b1, n >= 2040 && n <= 2056)
  endtask
  initial begin
    rst_n = 1'b0;
    zero_cross_in = 1'b0;
    conv_enable_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_idle();
    t_preset();
    t_convert();
    t_abort();
    t_enable();
    t_hold();
    end_sim();
  end
endmodule
`default_nettype wire
